// ===== hdl/frx_host.sv
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - replay only after at most depth writes (the host still replays after more, and sets err_rpl)
// - strobes held high during replay
// - wait recovery before next strobe
// - width expansion shares all controls
// - sample flags after worst settling time
// - cascade outputs ring to next inputs (the host drives cascade_in_n_o high in depth mode, leaving the ring open)
// - first device first-load low, others high
// - composite flags by ORing device flags
// - width and depth combine compound
module frx_host
   import frx_pkg::*;
#(
   parameter int DEPTH = FRX_DEPTH
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   output logic reset_n_o,
   output logic write_n_o,
   output logic read_n_o,
   output logic first_load_or_replay_n_o,
   output logic cascade_in_n_o,
   output logic [FRX_DATA_W-1:0] data_o,
   input wire logic [FRX_DATA_W-1:0] data_i,
   input wire logic empty_flag_n_i,
   input wire logic full_flag_n_i,
   input wire logic cascade_out_or_halfway_n_i
);
   frx_state_t state;
   logic [FRX_CNT_W-1:0] cnt;
   logic [1:0] phase;
   logic [FRX_DATA_W-1:0] wbuf;
   logic [FRX_DATA_W-1:0] rbuf;
   logic depth_mode;
   logic first_dev;
   logic [11:0] writes;
   logic pend_wr;
   logic pend_rd;
   logic pend_rst;
   logic pend_rpl;
   logic err_rpl;
   frx_flags_t sync1;
   frx_flags_t sync2;
   logic [FRX_DATA_W-1:0] dsync1;
   logic [FRX_DATA_W-1:0] dsync2;
   logic cmd_w;
   logic busy;
   logic launch_rst;
   logic launch_rpl;
   logic launch_wr;
   logic launch_rd;

   assign cmd_w = wr_i && addr_i == FRX_A_CTRL;
   assign busy = state != FRX_IDLE;
   // a request is cleared only when it starts (a replay also when a reset starts), so one queued meanwhile survives
   assign launch_rst = state == FRX_IDLE && pend_rst;
   assign launch_rpl = state == FRX_IDLE && !pend_rst && pend_rpl;
   assign launch_wr = state == FRX_IDLE && !pend_rst && !pend_rpl && pend_wr && sync2.full_n;
   assign launch_rd = state == FRX_IDLE && !pend_rst && !pend_rpl && !(pend_wr && sync2.full_n) && pend_rd
      && sync2.empty_n;

   ////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge clock_i) begin
      sync1 <= '{empty_n: empty_flag_n_i, full_n: full_flag_n_i, halfway_n: cascade_out_or_halfway_n_i};
      sync2 <= sync1;
      dsync1 <= data_i;
      dsync2 <= dsync1;
   end

   ////////////////////////////////////////////////////////////
   // command capture
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         pend_wr <= 1'b0;
         pend_rd <= 1'b0;
         pend_rst <= 1'b1;
         pend_rpl <= 1'b0;
         wbuf <= '0;
         depth_mode <= 1'b0;
         first_dev <= 1'b0;
      end else begin
         if (wr_i && addr_i == FRX_A_WDATA) begin
            wbuf <= wdata_i[FRX_DATA_W-1:0];
            pend_wr <= 1'b1;
         end else if (launch_wr) begin
            pend_wr <= 1'b0;
         end
         if (cmd_w && wdata_i[FRX_C_READ]) begin
            pend_rd <= 1'b1;
         end else if (launch_rd) begin
            pend_rd <= 1'b0;
         end
         if (cmd_w && wdata_i[FRX_C_RESET]) begin
            pend_rst <= 1'b1;
            depth_mode <= wdata_i[FRX_C_DEPTH];
            first_dev <= wdata_i[FRX_C_FIRST];
         end else if (launch_rst) begin
            pend_rst <= 1'b0;
         end
         // a device reset drops a queued replay, so none survives into depth mode
         if (cmd_w && wdata_i[FRX_C_REPLAY] && !depth_mode) begin
            pend_rpl <= 1'b1;
         end else if (launch_rpl || launch_rst) begin
            pend_rpl <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // pin sequencer
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state <= FRX_IDLE;
         cnt <= '0;
         phase <= '0;
         reset_n_o <= 1'b1;
         write_n_o <= 1'b1;
         read_n_o <= 1'b1;
         first_load_or_replay_n_o <= 1'b1;
         cascade_in_n_o <= 1'b0;
         data_o <= '0;
         rbuf <= '0;
         writes <= '0;
         err_rpl <= 1'b0;
      end else begin
         case (state)
            FRX_IDLE: begin
               cnt <= '0;
               phase <= '0;
               if (launch_rst) begin
                  state <= FRX_RST;
                  reset_n_o <= 1'b0;
                  cascade_in_n_o <= depth_mode;
                  first_load_or_replay_n_o <= !(first_dev && depth_mode);
               end else if (launch_rpl) begin
                  state <= FRX_RPL;
                  err_rpl <= writes > 12'(DEPTH);
                  first_load_or_replay_n_o <= 1'b0;
               end else if (launch_wr) begin
                  state <= FRX_WR;
                  data_o <= wbuf;
                  write_n_o <= 1'b0;
                  if (writes != 12'hFFF) begin
                     writes <= writes + 12'h001;
                  end
               end else if (launch_rd) begin
                  state <= FRX_RD;
                  read_n_o <= 1'b0;
               end
            end
            FRX_RST: begin
               cnt <= cnt + 1'b1;
               if (cnt == FRX_CNT_W'(FRX_RESET_CYC)) begin
                  reset_n_o <= 1'b1;
                  writes <= '0;
                  if (depth_mode) begin
                     cascade_in_n_o <= 1'b1;
                  end
                  state <= FRX_REC;
                  cnt <= '0;
               end
            end
            FRX_WR, FRX_RD: begin
               cnt <= cnt + 1'b1;
               if (cnt == FRX_CNT_W'(FRX_PULSE_CYC)) begin
                  if (state == FRX_RD) begin
                     rbuf <= dsync2;
                  end
                  write_n_o <= 1'b1;
                  read_n_o <= 1'b1;
                  state <= FRX_REC;
                  cnt <= '0;
               end
            end
            FRX_RPL: begin
               cnt <= cnt + 1'b1;
               if (cnt == FRX_CNT_W'(FRX_PULSE_CYC)) begin
                  first_load_or_replay_n_o <= 1'b1;
                  state <= FRX_REC;
                  cnt <= '0;
               end
            end
            FRX_REC: begin
               cnt <= cnt + 1'b1;
               if (cnt == FRX_CNT_W'(FRX_SETTLE_CYC)) begin
                  state <= FRX_IDLE;
                  cnt <= '0;
               end
            end
            default: state <= FRX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // register read port
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            FRX_A_CTRL: rdata_o <= 16'({depth_mode, first_dev, pend_rd, pend_rpl, pend_rst});
            FRX_A_RDATA: rdata_o <= 16'(rbuf);
            FRX_A_STAT: rdata_o <= 16'({err_rpl, busy, pend_wr, sync2.halfway_n, sync2.full_n, sync2.empty_n});
            FRX_A_WCNT: rdata_o <= 16'(writes);
            default: rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

   ////////////////////////////////////////////////////////////
   // checks
   sequence s_strobes_quiet;
      (write_n_o && read_n_o) [*6];
   endsequence

   property p_strobes_idle_in_replay;
      @(posedge clock_i) disable iff (!resetn_i)
      !first_load_or_replay_n_o && !depth_mode |-> write_n_o && read_n_o;
   endproperty
   a_strobes_idle_in_replay: assert property (p_strobes_idle_in_replay)
      else $error("strobe active during replay");

   property p_no_write_when_full;
      @(posedge clock_i) disable iff (!resetn_i)
      $fell(write_n_o) |-> $past(sync2.full_n);
   endproperty
   a_no_write_when_full: assert property (p_no_write_when_full)
      else $error("write started while full");

   property p_no_read_when_empty;
      @(posedge clock_i) disable iff (!resetn_i)
      $fell(read_n_o) |-> $past(sync2.empty_n);
   endproperty
   a_no_read_when_empty: assert property (p_no_read_when_empty)
      else $error("read started while empty");

   property p_recovery;
      @(posedge clock_i) disable iff (!resetn_i)
      $rose(first_load_or_replay_n_o) && state == FRX_REC |-> s_strobes_quiet;
   endproperty
   a_recovery: assert property (p_recovery)
      else $error("strobe inside recovery");

   property p_no_replay_depth;
      @(posedge clock_i) disable iff (!resetn_i)
      depth_mode && reset_n_o |-> state != FRX_RPL;
   endproperty
   a_no_replay_depth: assert property (p_no_replay_depth)
      else $error("replay in depth mode");

   // mode straps must not move while the device reset is low
   property p_mode_pins_steady;
      @(posedge clock_i) disable iff (!resetn_i)
      !reset_n_o && !$past(reset_n_o) |-> $stable(cascade_in_n_o) && $stable(first_load_or_replay_n_o);
   endproperty
   a_mode_pins_steady: assert property (p_mode_pins_steady)
      else $error("mode strap moved during device reset");

   property p_single_xi_low;
      @(posedge clock_i) disable iff (!resetn_i)
      $rose(reset_n_o) && !depth_mode |-> !cascade_in_n_o;
   endproperty
   a_single_xi_low: assert property (p_single_xi_low)
      else $error("cascade input high at single mode reset");
endmodule

// ===== hdl/frx_pkg.sv
package frx_pkg;
   localparam int FRX_DATA_W = 9;
   localparam int FRX_DEPTH = 1024;
   localparam int FRX_CLK_PS = 4000;
   // device timing (ns), slowest grade
   localparam int FRX_PULSE_NS = 80;
   localparam int FRX_RECOVER_NS = 20;
   localparam int FRX_FLAG_SETTLE_NS = 100;
   localparam int FRX_RESET_NS = 100;
   localparam int FRX_PULSE_CYC = (FRX_PULSE_NS * 1000 + FRX_CLK_PS - 1) / FRX_CLK_PS;
   localparam int FRX_RECOVER_CYC = (FRX_RECOVER_NS * 1000 + FRX_CLK_PS - 1) / FRX_CLK_PS;
   localparam int FRX_SETTLE_CYC = (FRX_FLAG_SETTLE_NS * 1000 + FRX_CLK_PS - 1) / FRX_CLK_PS;
   localparam int FRX_RESET_CYC = (FRX_RESET_NS * 1000 + FRX_CLK_PS - 1) / FRX_CLK_PS;
   localparam int FRX_CNT_W = 8;
   // register addresses
   localparam logic [3:0] FRX_A_CTRL = 4'h0;
   localparam logic [3:0] FRX_A_WDATA = 4'h1;
   localparam logic [3:0] FRX_A_RDATA = 4'h2;
   localparam logic [3:0] FRX_A_STAT = 4'h3;
   localparam logic [3:0] FRX_A_WCNT = 4'h4;
   // control bits
   localparam int FRX_C_RESET = 0;
   localparam int FRX_C_REPLAY = 1;
   localparam int FRX_C_READ = 2;
   localparam int FRX_C_FIRST = 3;
   localparam int FRX_C_DEPTH = 4;
   typedef enum logic [5:0] {
      FRX_IDLE = 6'b00_0001,
      FRX_RST = 6'b00_0010,
      FRX_WR = 6'b00_0100,
      FRX_RD = 6'b00_1000,
      FRX_RPL = 6'b01_0000,
      FRX_REC = 6'b10_0000
   } frx_state_t;
   typedef struct packed {
      logic empty_n;
      logic full_n;
      logic halfway_n;
   } frx_flags_t;
endpackage

// ===== tb/frx_dev_model.sv
`timescale 1ns/1ps
module frx_dev_model
   import frx_pkg::*;
#(
   parameter int DEPTH = FRX_DEPTH
) (
   input wire logic reset_n_i,
   input wire logic write_n_i,
   input wire logic read_n_i,
   input wire logic first_load_or_replay_n_i,
   input wire logic cascade_in_n_i,
   input wire logic [FRX_DATA_W-1:0] d_i,
   output logic [FRX_DATA_W-1:0] q_o,
   output logic empty_flag_n_o,
   output logic full_flag_n_o,
   output logic cascade_out_or_halfway_n_o
);
   logic [FRX_DATA_W-1:0] mem [DEPTH];
   int wp = 0, rp = 0, cnt = 0, nw = 0;
   logic dm = 1'b0, wok = 1'b0, rok = 1'b0, wact = 1'b1, ract = 1'b1, xo_n = 1'b1;
   initial q_o = '0;
   assign empty_flag_n_o = cnt != 0;
   assign full_flag_n_o = cnt != DEPTH;
   assign cascade_out_or_halfway_n_o = dm ? xo_n : (cnt < DEPTH / 2);
   always @(negedge reset_n_i) begin
      wp = 0;
      rp = 0;
      cnt = 0;
      nw = 0;
   end
   always @(posedge reset_n_i) begin
      dm = cascade_in_n_i;
      wact = !dm || !first_load_or_replay_n_i;
      ract = wact;
   end
   // cascade hand-over: take the write role first, then the read role
   always @(negedge cascade_in_n_i) begin
      if (reset_n_i && dm) begin
         if (!wact) wact = 1'b1;
         else ract = 1'b1;
      end
   end
   always @(negedge write_n_i) wok = reset_n_i && wact && cnt < DEPTH;
   always @(posedge write_n_i) begin
      if (wok) begin
         mem[wp] = d_i;
         wp = (wp + 1) % DEPTH;
         cnt++;
         nw++;
         if (dm && wp == 0) begin
            wact = 1'b0;
            xo_n = 1'b0;
         end
      end
      #20 xo_n = 1'b1;
   end
   always @(negedge read_n_i) begin
      rok = reset_n_i && ract && cnt > 0;
      if (rok) q_o = mem[rp];
   end
   // data held briefly, then no longer valid
   always @(posedge read_n_i) begin
      if (rok) begin
         rp = (rp + 1) % DEPTH;
         cnt--;
         if (dm && rp == 0) begin
            ract = 1'b0;
            xo_n = 1'b0;
         end
      end
      #5 q_o = ~q_o;
      #15 xo_n = 1'b1;
   end
   always @(negedge first_load_or_replay_n_i) begin
      if (reset_n_i && !dm) begin
         rp = 0;
         cnt = nw > DEPTH ? DEPTH : nw;
      end
   end
endmodule

// ===== tb/frx_host_tb.sv
`timescale 1ns/1ps
module frx_host_tb
   import frx_pkg::*;
;
   localparam int DP = 8;
   logic clock_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000, rdata_o;
   logic reset_n_o, write_n_o, read_n_o, first_load_or_replay_n_o, cascade_in_n_o;
   logic [FRX_DATA_W-1:0] data_o, data_i;
   logic empty_flag_n_i, full_flag_n_i, cascade_out_or_halfway_n_i;
   int n_mismatch = 0, num_checks = 0, n_xo = 0;
   // cascade pulses, counted only while the host straps depth mode
   always @(negedge cascade_out_or_halfway_n_i) if (cascade_in_n_o) n_xo++;
   initial forever #2 clock_i = ~clock_i;
   frx_host #(.DEPTH(DP)) uut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reset_n_o(reset_n_o), .write_n_o(write_n_o),
      .read_n_o(read_n_o), .first_load_or_replay_n_o(first_load_or_replay_n_o),
      .cascade_in_n_o(cascade_in_n_o), .data_o(data_o), .data_i(data_i), .empty_flag_n_i(empty_flag_n_i),
      .full_flag_n_i(full_flag_n_i), .cascade_out_or_halfway_n_i(cascade_out_or_halfway_n_i));
   frx_dev_model #(.DEPTH(DP)) dev (.reset_n_i(reset_n_o), .write_n_i(write_n_o), .read_n_i(read_n_o),
      .first_load_or_replay_n_i(first_load_or_replay_n_o), .cascade_in_n_i(cascade_in_n_o), .d_i(data_o),
      .q_o(data_i), .empty_flag_n_o(empty_flag_n_i), .full_flag_n_o(full_flag_n_i),
      .cascade_out_or_halfway_n_o(cascade_out_or_halfway_n_i));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // poll until no pending write and not busy
   task automatic idle();
      logic [15:0] st;
      int n;
      n = 0;
      repeat (3) @(posedge clock_i);
      do begin
         rd(FRX_A_STAT, st);
         n++;
      end while ((st[4] !== 1'b0 || st[3] !== 1'b0) && n < 400);
      if (n >= 400) n_mismatch++;
   endtask
   task automatic chkst(input int c);
      logic [15:0] st;
      rd(FRX_A_STAT, st);
      chk({13'h0, st[2:0]}, {13'h0, c < DP / 2, c != DP, c != 0});
   endtask
   task automatic pop(input int i, input int rem);
      logic [15:0] d;
      wr(FRX_A_CTRL, 16'(1 << FRX_C_READ));
      idle();
      rd(FRX_A_RDATA, d);
      chk(d, 16'h01a0 + 16'(i));
      chkst(rem);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      int i;
      logic [15:0] d;
      repeat (5) @(posedge clock_i);
      resetn_i <= 1'b1;
      idle();
      chkst(0);
      for (i = 0; i < DP; i++) begin
         wr(FRX_A_WDATA, 16'h01a0 + 16'(i));
         idle();
         chkst(i + 1);
      end
      rd(FRX_A_WCNT, d);
      chk(d, 16'(DP));
      for (i = 0; i < 3; i++) pop(i, DP - 1 - i);
      wr(FRX_A_CTRL, 16'(1 << FRX_C_REPLAY));
      idle();
      chkst(DP);
      for (i = 0; i < DP; i++) pop(i, DP - 1 - i);
      for (i = 0; i < 2; i++) begin
         wr(FRX_A_WDATA, 16'h01a0 + 16'(i));
         idle();
      end
      pop(0, 1);
      pop(1, 0);
      wr(FRX_A_CTRL, 16'(1 << FRX_C_REPLAY));
      idle();
      chkst(DP);
      rd(FRX_A_STAT, d);
      chk({15'h0, d[5]}, 16'h0001);
      // depth mode, first device, its ring left open
      wr(FRX_A_CTRL, 16'((1 << FRX_C_RESET) | (1 << FRX_C_FIRST) | (1 << FRX_C_DEPTH)));
      idle();
      for (i = 0; i < DP; i++) begin
         wr(FRX_A_WDATA, 16'h01b0 + 16'(i));
         idle();
      end
      rd(FRX_A_STAT, d);
      chk(d & 16'h0007, 16'h0005);
      chk(16'(n_xo), 16'h0001);
      for (i = 0; i < DP; i++) begin
         wr(FRX_A_CTRL, 16'(1 << FRX_C_READ));
         idle();
         rd(FRX_A_RDATA, d);
         chk(d, 16'h01b0 + 16'(i));
      end
      chk(16'(n_xo), 16'h0002);
      wr(FRX_A_WDATA, 16'h0055);
      idle();
      rd(FRX_A_STAT, d);
      chk(d & 16'h0007, 16'h0006);
      wr(FRX_A_CTRL, 16'(1 << FRX_C_RESET));
      idle();
      chkst(0);
      rd(FRX_A_WCNT, d);
      chk(d, 16'h0000);
      print_verdict();
   end
   initial begin
      #80000;
      n_mismatch++;
      print_verdict();
   end
endmodule
